// ==== bench/interrupt_enable_priority_bank_test.sv ====
// Purpose: self-checking bench for the enable and priority bank
// Assumes: zero-wait ahb-lite slave, level sources from src_model
// Notes: masks and reset values are written out here, not taken from src
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_priority_bank_test;
    // bus and control, the driven ones given values at time zero
    logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, irq;
    // source commands and the bank's outputs
    logic [47:0] en_cmd = '0, en_src_req, en_src_grant;
    logic [11:0] pri_cmd = '0, pri_en_cmd = '0, pri_src_req, pri_src_enable;
    logic [11:0] pri_src_grant;
    irq_bank_pkg::core_req_type core_req;
    int n_mismatch = 0, checked = 0, cycles = 0, i, f;
    // reset value and implemented bits of each word, in offset order
    logic [15:0] rst_tab [6] = '{16'h0, 16'h0, 16'h0, 16'h4444, 16'h4444,
        16'h4444};
    logic [15:0] msk_tab [6] = '{16'h0007, 16'h21ff, 16'h00f6, 16'h7777,
        16'h7777, 16'h7777};

    interrupt_enable_priority_bank u_dut (.hclk(hclk), .hresetn(hresetn),
        .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .en_src_req(en_src_req), .en_src_grant(en_src_grant),
        .pri_src_req(pri_src_req), .pri_src_enable(pri_src_enable),
        .pri_src_grant(pri_src_grant), .core_req(core_req), .irq(irq));

    src_model u_src (.hclk(hclk), .hresetn(hresetn), .en_cmd(en_cmd),
        .pri_cmd(pri_cmd), .pri_en_cmd(pri_en_cmd), .en_src_req(en_src_req),
        .pri_src_req(pri_src_req), .pri_src_enable(pri_src_enable));

    // 50 mhz clock
    initial begin
        forever #10 hclk = ~hclk;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    // compare and count
    task automatic chk(input string name, input logic [47:0] exp,
        input logic [47:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one single transfer; held until hready is seen at an edge
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsel <= 1'b1;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : xfer

    // read a word and compare it
    task automatic rdchk(input string name, input logic [7:0] a,
        input logic [47:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(name, exp, 48'(rd));
    endtask : rdchk

    // let requests and the registered core request settle; the third edge
    // lets the core request taken at the second edge be seen settled
    task automatic settle;
        repeat (3) @(posedge hclk);
    endtask : settle

    // counts, verdict, end of run
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // values after reset, then all ones written back through the masks
        for (i = 0; i < 6; i++) begin
            rdchk("reset", 8'(4 * i), 48'(rst_tab[i]));
            xfer(1'b1, 8'(4 * i), 32'hffffffff);
            rdchk("mask", 8'(4 * i), 48'(msk_tab[i]));
        end
        rdchk("unmapped", 8'h40, 48'h0);
        // frozen clock enable drops the write
        ce <= 1'b0;
        xfer(1'b1, 8'h00, 32'h0);
        ce <= 1'b1;
        rdchk("frozen", 8'h00, 48'h0007);
        // every source requesting: enable bits pass or block
        en_cmd <= '1;
        pri_cmd <= '1;
        pri_en_cmd <= '1;
        settle();
        chk("grant", 48'h00f6_21ff_0007, en_src_grant);
        xfer(1'b1, 8'h04, 32'h0);
        settle();
        chk("blocked", 48'h00f6_0000_0007, en_src_grant);
        chk("resp", 48'h0, 48'(hresp));
        rdchk("word4", 8'h08, 48'h00f6);
        // one field at level seven at a time, the others at zero
        for (i = 0; i < 12; i++) begin
            for (f = 0; f < 3; f++) begin
                xfer(1'b1, 8'(12 + 4 * f),
                    (f == i / 4) ? 32'h7 << (4 * (i % 4)) : 32'h0);
            end
            settle();
            chk("field", 48'(12'h1 << i), 48'(pri_src_grant));
            chk("top", 48'({1'b1, 4'(i), 3'h7}), 48'(core_req));
        end
        // source 8 at each level against source 9 at level three
        for (i = 1; i < 8; i++) begin
            xfer(1'b1, 8'h14, 32'h0030 | 32'(i));
            settle();
            chk("level", 48'({1'b1, (i >= 3) ? 4'h8 : 4'h9,
                (i >= 3) ? 3'(i) : 3'h3}), 48'(core_req));
        end
        // sticky status, enable mask and write-one clear
        xfer(1'b1, 8'h1c, 32'h1fff);
        xfer(1'b1, 8'h20, 32'h1fff);
        settle();
        chk("irq idle", 48'h0, 48'(irq));
        pri_cmd <= '0;
        settle();
        pri_cmd <= '1;
        settle();
        rdchk("status", 8'h18, 48'h0300);
        chk("irq on", 48'h1, 48'(irq));
        xfer(1'b1, 8'h20, 32'h0200);
        xfer(1'b1, 8'h1c, 32'h0200);
        settle();
        chk("irq masked", 48'h0, 48'(irq));
        rdchk("cleared", 8'h18, 48'h0100);
        // outside enable low: no grant, no core request
        pri_en_cmd <= '0;
        settle();
        chk("no grant", 48'h0, 48'(pri_src_grant));
        chk("no core", 48'h0, 48'(core_req.valid));
        summarize();
    end
endmodule : interrupt_enable_priority_bank_test
`default_nettype wire

// ==== bench/src_model.sv ====
// Purpose: far-side model of the interrupt sources feeding the bank
// Assumes: sources raise level flags synchronous to hclk
// Notes: flags drop in reset so no stale request reaches the bank
`timescale 1ns/1ps
`default_nettype none
module src_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // commands from the bench
    input wire logic [47:0] en_cmd,
    input wire logic [11:0] pri_cmd,
    input wire logic [11:0] pri_en_cmd,
    // level requests into the bank
    output logic [47:0] en_src_req,
    output logic [11:0] pri_src_req,
    output logic [11:0] pri_src_enable
);
    // each source raises its flag one clock after it is commanded
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_src_req <= '0;
            pri_src_req <= '0;
            pri_src_enable <= '0;
        end else begin
            en_src_req <= en_cmd;
            pri_src_req <= pri_cmd;
            pri_src_enable <= pri_en_cmd;
        end
    end
endmodule : src_model
`default_nettype wire

// ==== src/interrupt_enable_priority_bank.sv ====
// Purpose: per-source enable words 2..4 and priority words 0..2, with gating
// Assumes: requests are level flags synchronous to hclk
// Notes: AHB-Lite slave with zero wait states; read data in the low 16 bits
//
// Notes on behaviour
// - enable one passes request, zero blocks
// - unimplemented bits read zero, ignore writes
// - enable bits clear after reset
// - priority fields reset to binary 100
// - field 111 gives top level seven
// - fields 001 to 111 map levels one-seven
// - field 000 disables source regardless of enable
// - enable word 2 bits 2..0 gate three sources
// - word 3 bits 13, 8 live; bits 15, 14, 12..9 unimplemented
// - word 3 low byte gates eight sources
// - word 4 bits 7,6,5,4,2,1 gate sources
// - word 4 bits 15..8, 3, 0 read zero
// - priority word 0 fields at 14,10,6,2
// - priority word 1 holds four fields likewise
// - priority word 2 holds four fields likewise
// - bits 15, 11, 7, 3 read zero
//
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_priority_bank (
    // clock, reset and freeze
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // sources gated by enable words 2, 3, 4 (bit 16*k+n is word k+2 bit n)
    input wire logic [47:0] en_src_req,
    output logic [47:0] en_src_grant,
    // sources with priority fields; index 4*word+field, field 0 at bits 2..0
    input wire logic [11:0] pri_src_req,
    input wire logic [11:0] pri_src_enable,
    output logic [11:0] pri_src_grant,
    // prioritised request to the core
    output irq_bank_pkg::core_req_type core_req,
    // summary interrupt
    output logic irq
);
    // register state
    logic [15:0] en_word2_reg;
    logic [15:0] en_word3_reg;
    logic [15:0] en_word4_reg;
    logic [15:0] pri_word0_reg;
    logic [15:0] pri_word1_reg;
    logic [15:0] pri_word2_reg;
    logic [12:0] status_reg;
    logic [12:0] irq_enable_reg;
    // data-phase bookkeeping
    logic dp_write_reg;
    logic dp_read_reg;
    logic [7:0] dp_addr_reg;
    // previous grants for event detection
    logic [11:0] pri_grant_reg;
    logic en_any_reg;
    // registered core request
    irq_bank_pkg::core_req_type core_req_reg;
    irq_bank_pkg::core_req_type core_req_next;
    // address phase accepted this cycle
    wire addr_ok = hsel & htrans[1] & hready;
    wire [15:0] wd = hwdata[15:0];
    wire wr_en2 = dp_write_reg & (dp_addr_reg == irq_bank_pkg::OFS_EN_WORD2);
    wire wr_en3 = dp_write_reg & (dp_addr_reg == irq_bank_pkg::OFS_EN_WORD3);
    wire wr_en4 = dp_write_reg & (dp_addr_reg == irq_bank_pkg::OFS_EN_WORD4);
    wire wr_pri0 = dp_write_reg &
        (dp_addr_reg == irq_bank_pkg::OFS_PRI_WORD0);
    wire wr_pri1 = dp_write_reg &
        (dp_addr_reg == irq_bank_pkg::OFS_PRI_WORD1);
    wire wr_pri2 = dp_write_reg &
        (dp_addr_reg == irq_bank_pkg::OFS_PRI_WORD2);
    wire wr_clear = dp_write_reg & (dp_addr_reg == irq_bank_pkg::OFS_CLEAR);
    wire wr_ien = dp_write_reg &
        (dp_addr_reg == irq_bank_pkg::OFS_IRQ_ENABLE);
    // all priority words side by side, word 0 lowest
    wire [47:0] pri_all = {pri_word2_reg, pri_word1_reg, pri_word0_reg};
    wire [47:0] en_all = {en_word4_reg, en_word3_reg, en_word2_reg};
    // per-source priority fields
    logic [2:0] pri_field [0:11];
    // event bits: new grants rising
    wire [11:0] pri_rise = pri_src_grant & ~pri_grant_reg;
    wire en_any = |en_src_grant;
    wire [12:0] status_set = {en_any & ~en_any_reg, pri_rise};
    wire [12:0] clr_bits = wr_clear ? hwdata[12:0] : 13'h0000;

    // enable gating; unimplemented positions hold zero so never pass
    assign en_src_grant = en_src_req & en_all;

    // per-source field extraction and gating
    genvar gi;
    generate
        for (gi = 0; gi < irq_bank_pkg::PRI_SOURCES; gi++) begin : g_src
            // field n of word w sits at bits 4n+2..4n
            assign pri_field[gi] =
                pri_all[gi*irq_bank_pkg::PRI_FIELD_STRIDE +: 3];
            // flag, enable and nonzero priority all needed
            assign pri_src_grant[gi] = pri_src_req[gi] & pri_src_enable[gi] &
                (pri_field[gi] != irq_bank_pkg::PRI_DISABLED);
        end
    endgenerate

    // highest level wins; equal levels go to the lower index
    always_comb begin
        core_req_next = '0;
        for (int i = 0; i < irq_bank_pkg::PRI_SOURCES; i++) begin
            // field value is the level itself, 7 highest
            if (pri_src_grant[i] &&
                (!core_req_next.valid ||
                 pri_field[i] > core_req_next.level)) begin
                core_req_next.valid = 1'b1;
                core_req_next.index = 4'(i);
                core_req_next.level = pri_field[i];
            end
        end
    end

    // bus answers: never waits, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // read mux; unmapped and unimplemented bits return zero
    always_comb begin
        hrdata = 32'h0000_0000;
        if (dp_read_reg) begin
            unique case (dp_addr_reg)
                irq_bank_pkg::OFS_EN_WORD2: hrdata[15:0] = en_word2_reg;
                irq_bank_pkg::OFS_EN_WORD3: hrdata[15:0] = en_word3_reg;
                irq_bank_pkg::OFS_EN_WORD4: hrdata[15:0] = en_word4_reg;
                irq_bank_pkg::OFS_PRI_WORD0: hrdata[15:0] = pri_word0_reg;
                irq_bank_pkg::OFS_PRI_WORD1: hrdata[15:0] = pri_word1_reg;
                irq_bank_pkg::OFS_PRI_WORD2: hrdata[15:0] = pri_word2_reg;
                irq_bank_pkg::OFS_STATUS: hrdata[12:0] = status_reg;
                irq_bank_pkg::OFS_IRQ_ENABLE: hrdata[12:0] = irq_enable_reg;
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_reg <= 1'b0;
            dp_read_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
        end else if (ce) begin
            dp_write_reg <= addr_ok & hwrite;
            dp_read_reg <= addr_ok & ~hwrite;
            dp_addr_reg <= haddr[7:0];
        end
    end

    // enable words, masked on write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_word2_reg <= irq_bank_pkg::EN_WORD_RESET;
            en_word3_reg <= irq_bank_pkg::EN_WORD_RESET;
            en_word4_reg <= irq_bank_pkg::EN_WORD_RESET;
        end else if (ce) begin
            if (wr_en2)
                en_word2_reg <= wd & irq_bank_pkg::EN_WORD2_MASK;
            if (wr_en3)
                en_word3_reg <= wd & irq_bank_pkg::EN_WORD3_MASK;
            if (wr_en4)
                en_word4_reg <= wd & irq_bank_pkg::EN_WORD4_MASK;
        end
    end

    // priority words, separators masked off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pri_word0_reg <= irq_bank_pkg::PRI_WORD_RESET;
            pri_word1_reg <= irq_bank_pkg::PRI_WORD_RESET;
            pri_word2_reg <= irq_bank_pkg::PRI_WORD_RESET;
        end else if (ce) begin
            if (wr_pri0)
                pri_word0_reg <= wd & irq_bank_pkg::PRI_WORD_MASK;
            if (wr_pri1)
                pri_word1_reg <= wd & irq_bank_pkg::PRI_WORD_MASK;
            if (wr_pri2)
                pri_word2_reg <= wd & irq_bank_pkg::PRI_WORD_MASK;
        end
    end

    // sticky status: a new event beats a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= 13'h0000;
            irq_enable_reg <= 13'h0000;
            pri_grant_reg <= 12'h000;
            en_any_reg <= 1'b0;
            core_req_reg <= '0;
        end else if (ce) begin
            status_reg <= (status_reg & ~clr_bits) | status_set;
            if (wr_ien)
                irq_enable_reg <= hwdata[12:0];
            pri_grant_reg <= pri_src_grant;
            en_any_reg <= en_any;
            core_req_reg <= core_req_next;
        end
    end

    assign core_req = core_req_reg;
    assign irq = |(status_reg & irq_enable_reg);

    // helper: low in the first cycle after reset release
    logic seen_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            seen_reg <= 1'b0;
        else
            seen_reg <= 1'b1;
    end

    a_reset_values: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !seen_reg |-> (en_all == 48'h0) && (pri_word0_reg == 16'h4444) &&
            (pri_word1_reg == 16'h4444) && (pri_word2_reg == 16'h4444))
        else $error("registers not at reset values");

    a_en_block: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !en_word3_reg[8] |-> !en_src_grant[24])
        else $error("disabled source passed");

    a_pri_zero_off: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (pri_word1_reg[14:12] == 3'h0) |-> !pri_src_grant[7])
        else $error("priority zero source granted");

    a_sep_bits_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (pri_all & ~{3{16'h7777}}) == 48'h0)
        else $error("separator bit set");

    a_en4_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && wr_en4) |=> en_word4_reg == ($past(hwdata[15:0]) & 16'h00f6))
        else $error("enable word 4 write wrong");

    a_unimpl_read: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (dp_read_reg && dp_addr_reg == 8'h04) |-> hrdata[15:14] == 2'b00 &&
            hrdata[12:9] == 4'h0 && hrdata[31:16] == 16'h0)
        else $error("unimplemented bits read nonzero");

    a_top_level: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && pri_src_grant[0] && pri_field[0] == 3'h7) |=>
            core_req.valid && core_req.level == 3'h7)
        else $error("level seven not on top");

    a_set_wins: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ce && pri_rise[3] && wr_clear && hwdata[3]) |=> status_reg[3])
        else $error("event lost to clear");

    a_status_hold: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (status_reg[0] && !(wr_clear && hwdata[0])) |=> status_reg[0])
        else $error("sticky bit dropped");
endmodule : interrupt_enable_priority_bank
`default_nettype wire

// ==== src/irq_bank_pkg.sv ====
// Purpose: constants and types for the interrupt enable and priority bank
// Assumes: AHB-Lite slave, one clock, 16-bit words in the low bus lanes
// Notes: every offset and mask, and the enable and priority word reset values, used by the bank live here
package irq_bank_pkg;
    // byte offsets of the registers
    localparam logic [7:0] OFS_EN_WORD2 = 8'h00;
    localparam logic [7:0] OFS_EN_WORD3 = 8'h04;
    localparam logic [7:0] OFS_EN_WORD4 = 8'h08;
    localparam logic [7:0] OFS_PRI_WORD0 = 8'h0c;
    localparam logic [7:0] OFS_PRI_WORD1 = 8'h10;
    localparam logic [7:0] OFS_PRI_WORD2 = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_CLEAR = 8'h1c;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
    // implemented bits of each word; all others read zero and drop writes
    localparam logic [15:0] EN_WORD2_MASK = 16'h0007;
    localparam logic [15:0] EN_WORD3_MASK = 16'h21ff;
    localparam logic [15:0] EN_WORD4_MASK = 16'h00f6;
    localparam logic [15:0] PRI_WORD_MASK = 16'h7777;
    // values after reset
    localparam logic [15:0] EN_WORD_RESET = 16'h0000;
    localparam logic [15:0] PRI_WORD_RESET = 16'h4444;
    localparam logic [2:0] PRI_DISABLED = 3'h0;
    // field layout of a priority word
    localparam int PRI_FIELDS = 4;
    localparam int PRI_FIELD_STRIDE = 4;
    localparam int PRI_SOURCES = 12;
    // status word: one bit per priority source, then one summary bit
    localparam int STATUS_BITS = 13;
    localparam int STATUS_EN_BIT = 12;
    // prioritised request handed to the core
    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [2:0] level;
    } core_req_type;
endpackage : irq_bank_pkg
